// [core/fsr_pkg.sv]
// Operation
// - Speed field 15:14 reads 10 for 1000, 01 for 100, 00 for 10 Mbps.
// - Speed, duplex and pause fields hold meaning only once resolved reads 1.
// - Resolved sets on negotiation complete, and also with negotiation off.
// - In 100BASE-FX mode the speed field is fixed at the 100 Mbps code.
// - Duplex bit 13, 1 full; in 100BASE-FX it copies the fiber duplex control.
// - Page bit 12 latches high on a received page; stays 0 in 100BASE-FX.
// - Resolved bit 11 forced 1 with negotiation off or in 100BASE-FX.
// - Force-unresolved control bit drives resolved to 0 over everything else.
// - Bit 10 shows the live, unlatched fiber link state.
// - Bits 7:6 latch the received remote fault code.
// - Bit 5 shows receive sync, 1 when acquired.
// - Bit 4 is inverted energy detect, 1 means no energy; resets to 1.
// - Bit 3 mirrors transmit pause resolution, unused inside; 0 in 100BASE-FX.
// - Bit 2 mirrors receive pause resolution, unused inside; 0 in 100BASE-FX.
// - Enable bits 14 to 4, except 6, are writable per-source interrupt enables.
// - Enable bits 15, 6 and 3:0 always read zero.
// - Two-bit mode: 00 100BASE-FX, 01 1000BASE-X, 10 SGMII system, 11 SGMII media.
`default_nettype none
package fsr_pkg;
	// ************************************************
	// Register indices, byte address is index times four
	// ************************************************
	localparam logic [5:0] FSR_IDX_STATUS = 6'h11;
	localparam logic [5:0] FSR_IDX_IEN = 6'h12;
	localparam logic [5:0] FSR_IDX_IST = 6'h14;
	localparam logic [5:0] FSR_IDX_ICLR = 6'h15;
	localparam logic [5:0] FSR_IDX_CTRL = 6'h16;
	// ************************************************
	// Field positions
	// ************************************************
	localparam int FSR_B_SPD = 14;
	localparam int FSR_B_DUP = 13;
	localparam int FSR_B_PAGE = 12;
	localparam int FSR_B_RES = 11;
	localparam int FSR_B_LINK = 10;
	localparam int FSR_B_SYMERR = 9;
	localparam int FSR_B_FCAR = 8;
	localparam int FSR_B_FIFO = 7;
	localparam int FSR_B_RF = 6;
	localparam int FSR_B_RFEV = 5;
	localparam int FSR_B_SYNC = 5;
	localparam int FSR_B_NRG = 4;
	localparam int FSR_B_TXP = 3;
	localparam int FSR_B_RXP = 2;
	localparam int FSR_C_AN_EN = 2;
	localparam int FSR_C_FX_DUP = 3;
	localparam int FSR_C_UNRES = 4;
	localparam int FSR_C_SWRST = 15;
	localparam logic [15:0] FSR_IEN_MASK = 16'h7fb0;
	// ************************************************
	// Codes
	// ************************************************
	localparam logic [1:0] FSR_MODE_FX = 2'h0;
	localparam logic [1:0] FSR_MODE_1000X = 2'h1;
	localparam logic [1:0] FSR_MODE_SGMII_SYS = 2'h2;
	localparam logic [1:0] FSR_MODE_SGMII_MED = 2'h3;
	localparam logic [1:0] FSR_SPD_1000 = 2'h2;
	localparam logic [1:0] FSR_SPD_100 = 2'h1;
	localparam logic [1:0] FSR_SPD_10 = 2'h0;
	// ************************************************
	// State and reset values
	// ************************************************
	typedef struct packed {
		logic [15:0] ien;
		logic [15:0] ist;
		logic [1:0] mode;
		logic an_en;
		logic fx_dup;
		logic unres;
		logic page;
		logic [1:0] rf;
		logic link;
		logic sync;
		logic nrg_n;
		logic [1:0] spd;
		logic dup;
		logic res;
		logic txp;
		logic rxp;
		logic an_prev;
		logic wr_pend;
		logic [5:0] wr_idx;
		logic [31:0] rdata;
		logic ready;
		logic resp;
		logic irq;
	} fsr_state_t;
	localparam logic [1:0] FSR_MODE_RST = FSR_MODE_1000X;
	localparam logic FSR_AN_EN_RST = 1'h1;
	localparam logic FSR_NRG_N_RST = 1'h1;
endpackage
`default_nettype wire

// [core/fsr_regs.sv]
// Register access over AHB-Lite was left to the implementer.
`default_nettype none
module fsr_regs
	import fsr_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output var logic [31:0] HRDATA,
	output var logic HREADYOUT,
	output var logic HRESP,
	input wire logic AN_DONE,
	input wire logic [1:0] AN_SPEED,
	input wire logic AN_DUPLEX,
	input wire logic AN_TX_PAUSE,
	input wire logic AN_RX_PAUSE,
	input wire logic PAGE_RX,
	input wire logic LINK_UP,
	input wire logic SYNC_OK,
	input wire logic ENERGY,
	input wire logic [1:0] RF_CODE,
	input wire logic SYM_ERR,
	input wire logic FALSE_CARRIER,
	input wire logic FIFO_ERR,
	output var logic IRQ
);

	// ************************************************
	// Read word builders
	// ************************************************
	function automatic logic [15:0] status_word(input fsr_state_t s);
		logic [15:0] w;
		w = 16'h0000;
		w[FSR_B_SPD+1 -: 2] = s.spd;
		w[FSR_B_DUP] = s.dup;
		w[FSR_B_PAGE] = s.page;
		w[FSR_B_RES] = s.res;
		w[FSR_B_LINK] = s.link;
		w[FSR_B_RF+1 -: 2] = s.rf;
		w[FSR_B_SYNC] = s.sync;
		w[FSR_B_NRG] = s.nrg_n;
		w[FSR_B_TXP] = s.txp;
		w[FSR_B_RXP] = s.rxp;
		return w;
	endfunction

	function automatic logic [15:0] ctrl_word(input fsr_state_t s);
		logic [15:0] w;
		w = 16'h0000;
		w[1:0] = s.mode;
		w[FSR_C_AN_EN] = s.an_en;
		w[FSR_C_FX_DUP] = s.fx_dup;
		w[FSR_C_UNRES] = s.unres;
		return w;
	endfunction

	// ************************************************
	// State
	// ************************************************
	fsr_state_t s_q;
	fsr_state_t s_d;

	always_comb begin
		logic fx;
		logic acc;
		logic hit;
		logic rd_stat;
		logic swr;
		logic [5:0] idx;
		logic [15:0] ev;
		logic [15:0] clr;
		logic [15:0] rw;
		fx = 1'b0;
		acc = 1'b0;
		hit = 1'b0;
		rd_stat = 1'b0;
		swr = 1'b0;
		idx = 6'h00;
		ev = 16'h0000;
		clr = 16'h0000;
		rw = 16'h0000;
		s_d = s_q;

		// Address phase decode
		acc = HSEL & HREADY & HTRANS[1];
		hit = (HADDR[31:8] == 24'h000000);
		idx = hit ? HADDR[7:2] : 6'h00;
		rd_stat = acc & ~HWRITE & (idx == FSR_IDX_STATUS);

		// Data phase write
		if (s_q.wr_pend) begin
			case (s_q.wr_idx)
				FSR_IDX_IEN: begin
					s_d.ien = HWDATA[15:0] & FSR_IEN_MASK;
				end
				FSR_IDX_ICLR: begin
					clr = HWDATA[15:0];
				end
				FSR_IDX_CTRL: begin
					s_d.mode = HWDATA[1:0];
					s_d.an_en = HWDATA[FSR_C_AN_EN];
					s_d.fx_dup = HWDATA[FSR_C_FX_DUP];
					s_d.unres = HWDATA[FSR_C_UNRES];
					swr = HWDATA[FSR_C_SWRST];
				end
				default: begin
					clr = 16'h0000;
				end
			endcase
		end

		// Live status resolution
		fx = (s_q.mode == FSR_MODE_FX);
		if (s_q.unres) begin
			s_d.res = 1'b0;
		end else if (fx | ~s_q.an_en) begin
			s_d.res = 1'b1;
		end else begin
			s_d.res = AN_DONE;
		end
		s_d.spd = fx ? FSR_SPD_100 : AN_SPEED;
		s_d.dup = fx ? s_q.fx_dup : AN_DUPLEX;
		s_d.txp = fx ? 1'b0 : AN_TX_PAUSE;
		s_d.rxp = fx ? 1'b0 : AN_RX_PAUSE;
		s_d.link = LINK_UP;
		s_d.sync = SYNC_OK;
		s_d.nrg_n = ~ENERGY;
		s_d.an_prev = AN_DONE;

		// Latched-high bits, a new event wins over the read clear
		s_d.page = ~fx & (PAGE_RX | (s_q.page & ~rd_stat));
		if (rd_stat | (RF_CODE != 2'h0)) begin
			s_d.rf = RF_CODE;
		end

		// Software reset
		if (swr) begin
			s_d.ien[FSR_B_RFEV] = 1'b0;
			s_d.page = 1'b0;
			s_d.rf = 2'h0;
			s_d.nrg_n = FSR_NRG_N_RST;
		end

		// Interrupt events
		ev[FSR_B_SPD] = (s_d.spd != s_q.spd);
		ev[FSR_B_DUP] = (s_d.dup != s_q.dup);
		ev[FSR_B_PAGE] = PAGE_RX & ~fx;
		ev[FSR_B_RES] = AN_DONE & ~s_q.an_prev;
		ev[FSR_B_LINK] = (LINK_UP != s_q.link);
		ev[FSR_B_SYMERR] = SYM_ERR;
		ev[FSR_B_FCAR] = FALSE_CARRIER;
		ev[FSR_B_FIFO] = FIFO_ERR;
		ev[FSR_B_RFEV] = (s_d.rf != s_q.rf) & (s_d.rf != 2'h0);
		ev[FSR_B_NRG] = (s_d.nrg_n != s_q.nrg_n);
		s_d.ist = ((s_q.ist & ~clr) | ev) & FSR_IEN_MASK;
		s_d.irq = |(s_d.ist & s_d.ien);

		// Address phase capture and read data
		s_d.wr_pend = acc & HWRITE;
		s_d.wr_idx = idx;
		s_d.ready = 1'b1;
		s_d.resp = 1'b0;
		if (acc & ~HWRITE) begin
			case (idx)
				FSR_IDX_STATUS: begin
					rw = status_word(s_q);
				end
				FSR_IDX_IEN: begin
					rw = s_d.ien;
				end
				FSR_IDX_IST: begin
					rw = s_q.ist;
				end
				FSR_IDX_CTRL: begin
					rw = ctrl_word(s_d);
				end
				default: begin
					rw = 16'h0000;
				end
			endcase
		end
		s_d.rdata = {16'h0000, rw};
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			s_q <= '0;
			s_q.mode <= FSR_MODE_RST;
			s_q.an_en <= FSR_AN_EN_RST;
			s_q.nrg_n <= FSR_NRG_N_RST;
			s_q.ready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	assign HRDATA = s_q.rdata;
	assign HREADYOUT = s_q.ready;
	assign HRESP = s_q.resp;
	assign IRQ = s_q.irq;

endmodule
`default_nettype wire

// [test/fsr_partner.sv]
`default_nettype none
// ****
// Fiber side model
// ****
module fsr_partner (
	input wire logic CLK,
	input wire logic [14:0] PHY_CMD,
	output logic AN_DONE,
	output logic [1:0] AN_SPEED,
	output logic AN_DUPLEX,
	output logic AN_TX_PAUSE,
	output logic AN_RX_PAUSE,
	output logic PAGE_RX,
	output logic LINK_UP,
	output logic SYNC_OK,
	output logic ENERGY,
	output logic [1:0] RF_CODE,
	output logic SYM_ERR,
	output logic FALSE_CARRIER,
	output logic FIFO_ERR
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [14:0] q = 15'h0;
	always_ff @(posedge CLK) q <= PHY_CMD;
	assign {AN_DONE, AN_SPEED, AN_DUPLEX, AN_TX_PAUSE, AN_RX_PAUSE, PAGE_RX, LINK_UP, SYNC_OK,
		ENERGY, RF_CODE, SYM_ERR, FALSE_CARRIER, FIFO_ERR} = q;
endmodule
`default_nettype wire

// [test/fsr_assertions.sv]
`default_nettype none
// ****
// Port checker
// ****
module fsr_assertions
	import fsr_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic LINK_UP,
	input wire logic SYNC_OK,
	input wire logic ENERGY,
	input wire logic [1:0] RF_CODE,
	input wire logic IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rd_q, wr_q, st_q, en_q;
	always_ff @(posedge CLK) begin
		rd_q <= HSEL && HREADY && HTRANS[1] && !HWRITE;
		wr_q <= HSEL && HREADY && HTRANS[1] && HWRITE;
		st_q <= HADDR == 32'h44;
		en_q <= HADDR == 32'h48;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	sequence s_st;
		rd_q && st_q;
	endsequence
	property p_okay; HREADYOUT && !HRESP; endproperty
	a_okay: assert property (p_okay) else $error("bad response");
	property p_idle; !rd_q |-> HRDATA == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("data outside read");
	property p_link; s_st |-> HRDATA[10] == $past(LINK_UP, 2); endproperty
	a_link: assert property (p_link) else $error("link bit");
	property p_sync; s_st |-> HRDATA[5] == $past(SYNC_OK, 2); endproperty
	a_sync: assert property (p_sync) else $error("sync bit");
	property p_nrg; s_st |-> HRDATA[4] != $past(ENERGY, 2); endproperty
	a_nrg: assert property (p_nrg) else $error("energy bit");
	property p_ien; rd_q && en_q |-> (HRDATA & {16'hffff, ~FSR_IEN_MASK}) == 32'h0; endproperty
	a_ien: assert property (p_ien) else $error("enable reserved");
	property p_rf; s_st and $past(RF_CODE, 2) != 2'h0 |-> HRDATA[7:6] != 2'h0; endproperty
	a_rf: assert property (p_rf) else $error("fault code");
	property p_irqclr; $fell(IRQ) |-> $past(wr_q) || !$past(RSTN); endproperty
	a_irqclr: assert property (p_irqclr) else $error("irq fell");
endmodule
bind fsr_regs fsr_assertions chk_u (.*);
`default_nettype wire

// [test/tb_top.sv]
`default_nettype none
// ****
// Bench
// ****
module tb_top
	import fsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 1'h0, RSTN = 1'h0, HSEL = 1'h0, HWRITE = 1'h0;
	logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, rd;
	logic [1:0] HTRANS = 2'h0;
	logic [2:0] HSIZE = 3'h2;
	logic [14:0] PHY_CMD = 15'h0;
	wire logic [31:0] HRDATA;
	wire logic HREADYOUT, HRESP, IRQ, HREADY;
	wire logic AN_DONE, AN_DUPLEX, AN_TX_PAUSE, AN_RX_PAUSE, PAGE_RX, LINK_UP, SYNC_OK;
	wire logic ENERGY, SYM_ERR, FALSE_CARRIER, FIFO_ERR;
	wire logic [1:0] AN_SPEED, RF_CODE;
	int n_mismatch = 0, comparisons = 0;
	assign HREADY = HREADYOUT;
	always #2 CLK = ~CLK;
	fsr_regs dut_u (.*);
	fsr_partner phy_u (.*);
	task automatic print_verdict();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic wait_rdy();
		for (int i = 0; i <= 20; i++) begin
			@(posedge CLK);
			if (HREADY === 1'h1) break;
			if (i == 20) begin
				n_mismatch++;
				print_verdict();
			end
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] wd);
		HSEL <= 1'h1;
		HTRANS <= 2'h2;
		HADDR <= {24'h0, idx, 2'h0};
		HWRITE <= w;
		wait_rdy();
		HTRANS <= 2'h0;
		HWDATA <= wd;
		wait_rdy();
		rd = HRDATA;
		// Live status bits settle one cycle after a control write lands
		if (w && idx == FSR_IDX_CTRL) @(posedge CLK);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
		bus(1'h0, idx, 32'h0);
		chk(rd, exp);
	endtask
	task automatic irq_is(input logic e);
		#1;
		chk({31'h0, IRQ}, {31'h0, e});
		@(posedge CLK);
	endtask
	task automatic phy(input logic [14:0] c);
		PHY_CMD <= c;
		repeat (3) @(posedge CLK);
	endtask
	initial begin
		repeat (3) @(posedge CLK);
		RSTN <= 1'h1;
		rdc(FSR_IDX_STATUS, 32'h10);
		rdc(FSR_IDX_IEN, 32'h0);
		bus(1'h1, FSR_IDX_IEN, 32'hffff);
		rdc(FSR_IDX_IEN, 32'h7fb0);
		for (int s = 0; s < 3; s++) begin
			phy(15'h4ce0 | 15'(s << 12));
			rdc(FSR_IDX_STATUS, {16'h0, 2'(s), 14'h2c28});
		end
		phy(15'h2ce0);
		bus(1'h1, FSR_IDX_CTRL, 32'h1);
		rdc(FSR_IDX_STATUS, 32'hac28);
		phy(15'h6ce0);
		bus(1'h1, FSR_IDX_CTRL, 32'h15);
		rdc(FSR_IDX_STATUS, 32'ha428);
		bus(1'h1, FSR_IDX_CTRL, 32'h8);
		phy(15'h67e0);
		rdc(FSR_IDX_STATUS, 32'h6c20);
		phy(15'h6ce0);
		bus(1'h1, FSR_IDX_CTRL, 32'h5);
		bus(1'h0, FSR_IDX_STATUS, 32'h0);
		phy(15'h6df0);
		phy(15'h6cf0);
		rdc(FSR_IDX_STATUS, 32'hbca8);
		phy(15'h6ce0);
		rdc(FSR_IDX_STATUS, 32'haca8);
		bus(1'h1, FSR_IDX_IEN, 32'h200);
		bus(1'h1, FSR_IDX_ICLR, 32'hffff);
		irq_is(1'h0);
		phy(15'h6ce4);
		phy(15'h6ce0);
		irq_is(1'h1);
		phy(15'h6ce1);
		rdc(FSR_IDX_IST, 32'h280);
		bus(1'h1, FSR_IDX_ICLR, 32'h200);
		irq_is(1'h0);
		bus(1'h1, FSR_IDX_STATUS, 32'hffff);
		rdc(FSR_IDX_STATUS, 32'hac28);
		rdc(FSR_IDX_ICLR, 32'h0);
		rdc(6'h3f, 32'h0);
		bus(1'h1, FSR_IDX_IEN, 32'h7fb0);
		bus(1'h1, FSR_IDX_CTRL, 32'h8005);
		rdc(FSR_IDX_IEN, 32'h7f90);
		print_verdict();
	end
endmodule
`default_nettype wire
